// File: design/mcg_top.sv
// machine clock generator: clock modes, dividers, pll rate model, timebase taps
// assumes oscillators appear as one-cycle ticks synchronous to clk, and the
// pll output is modelled as a tick stream at mult times the oscillation rate
module mcg_top (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // oscillator ticks, one per source clock period
  input wire logic hs_osc_in,
  input wire logic ls_osc_in,
  // control settings, taken when ctrl_write pulses
  input wire logic ctrl_write,
  input wire logic subclk_select,
  input wire logic pll_select,
  input wire logic [1:0] wait_select,
  input wire logic pll_mult_bit0,
  input wire logic pll_mult_bit1,
  input wire logic pll_mult_bit2,
  input wire logic sub_div_select,
  // clock enables out
  output logic mclk_tick,
  output logic main_tick_out,
  output logic watch_tick,
  output logic pll_tick_out,
  output logic [mcg_pkg::PERI_TAPS-1:0] peri_tick,
  // status
  output logic sub_running,
  output logic pll_running,
  output logic osc_waiting
);
  import mcg_pkg::*;

  logic sub_div; // 1: divide by 2
  logic subclk_sel_q; // 0 requests sub-clock
  logic pll_sel_q; // 0 requests pll
  logic [1:0] wait_sel_q;
  logic [2:0] mult_code;
  logic main_ph; // oscillation halving phase
  logic main_tick; // main clock enable
  logic [1:0] ls_cnt; // sub divider count
  logic sub_tick; // sub-clock enable
  logic [PER_W-1:0] hs_gap; // clk cycles since last oscillation tick
  logic [PER_W-1:0] hs_per; // measured oscillation period
  logic [PER_W+2:0] pll_acc; // rate accumulator
  logic [2:0] mult_val; // multiplier 1..6
  logic pll_tick; // pll clock enable
  logic [TBT_W-1:0] tbt; // timebase timer
  logic tbt_clr; // clear request from mode logic
  logic wait_done; // selected wait tap reached
  mcg_mode_t mode;
  logic cur_tick; // enable of the source now driving the machine
  logic want_sub;
  logic want_pll;

  // control settings; reset returns all of them to defaults
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sub_div <= RST_SUB_DIV;
      subclk_sel_q <= RST_SUBCLK_SEL;
      pll_sel_q <= RST_PLL_SEL;
      wait_sel_q <= RST_WAIT_SEL;
      mult_code <= RST_MULT;
    end else if (ctrl_write) begin
      sub_div <= sub_div_select;
      subclk_sel_q <= subclk_select;
      pll_sel_q <= pll_select;
      wait_sel_q <= wait_select;
      // multiplier frozen while pll runs; code 111 is dropped as a safety net
      if (mode != MCG_PLL && {pll_mult_bit2, pll_mult_bit1, pll_mult_bit0} != MULT_ILLEGAL) begin
        mult_code <= {pll_mult_bit2, pll_mult_bit1, pll_mult_bit0};
      end
    end
  end

  // main clock: every second oscillation tick
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_ph <= 1'b0;
    end else if (hs_osc_in) begin
      main_ph <= ~main_ph;
    end
  end
  assign main_tick = hs_osc_in && main_ph;

  // sub-clock divider, /4 or /2 of the low-speed source
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ls_cnt <= 2'h0;
    end else if (ls_osc_in) begin
      ls_cnt <= sub_tick ? 2'h0 : ls_cnt + 2'h1;
    end
  end
  assign sub_tick = ls_osc_in && (ls_cnt == (sub_div ? 2'h1 : 2'h3));

  // multiplier decode; unused codes fall back to x1
  always_comb begin
    unique case (mult_code)
      3'h1: mult_val = 3'h2;
      3'h2: mult_val = 3'h3;
      3'h3: mult_val = 3'h4;
      3'h6: mult_val = 3'h6;
      default: mult_val = 3'h1;
    endcase
  end

  // oscillation period measurement; pll rate follows the source
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_gap <= '0;
      hs_per <= '0;
    end else if (hs_osc_in) begin
      hs_gap <= {{(PER_W-1){1'b0}}, 1'b1};
      hs_per <= hs_gap;
    end else if (hs_gap != '1) begin
      hs_gap <= hs_gap + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // pll tick stream: mult ticks per oscillation period, at most one per clk
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_acc <= '0;
    end else if (hs_per == '0) begin
      pll_acc <= '0; // not locked to a source yet
    end else if (pll_tick) begin
      pll_acc <= pll_acc + {{PER_W{1'b0}}, mult_val} - {3'h0, hs_per};
    end else begin
      pll_acc <= pll_acc + {{PER_W{1'b0}}, mult_val};
    end
  end
  assign pll_tick = (hs_per != '0) && (pll_acc >= {3'h0, hs_per});

  // timebase timer on the main clock, cleared when a wait starts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tbt <= '0;
    end else if (tbt_clr) begin
      tbt <= '0;
    end else if (main_tick) begin
      tbt <= tbt + {{(TBT_W-1){1'b0}}, 1'b1};
    end
  end

  // wait tap, fixed for pll lock; masked while a clear is pending, as stale bits would end it
  always_comb begin
    if (mode == MCG_WAIT_PLL) begin
      wait_done = !tbt_clr && tbt[PLL_WAIT_TAP];
    end else begin
      unique case (wait_sel_q)
        2'h0: wait_done = !tbt_clr && tbt[WAIT_TAP0];
        2'h1: wait_done = !tbt_clr && tbt[WAIT_TAP1];
        2'h2: wait_done = !tbt_clr && tbt[WAIT_TAP2];
        2'h3: wait_done = !tbt_clr && tbt[WAIT_TAP3];
      endcase
    end
  end

  // requested mode; sub select outranks pll select
  assign want_sub = !subclk_sel_q;
  assign want_pll = subclk_sel_q && !pll_sel_q;

  // mode sequencer; pll entry and exit land on a tick of the old source (main, pll),
  // but sub entry lands on a sub tick and the oscillation wait ends on its timebase tap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= MCG_MAIN;
      tbt_clr <= 1'b0;
    end else begin
      tbt_clr <= 1'b0;
      unique case (mode)
        MCG_MAIN: begin
          if (want_sub) begin
            mode <= MCG_TO_SUB;
          end else if (want_pll) begin
            mode <= MCG_WAIT_PLL;
            tbt_clr <= 1'b1;
          end
        end
        MCG_TO_SUB: begin
          if (!want_sub) begin
            mode <= MCG_MAIN; // abandoned before it took effect
          end else if (sub_tick) begin
            mode <= MCG_SUB;
          end
        end
        MCG_SUB: begin
          if (!want_sub && sub_tick) begin
            mode <= MCG_WAIT_OSC;
            tbt_clr <= 1'b1;
          end
        end
        MCG_WAIT_OSC: begin
          if (want_sub) begin
            mode <= MCG_SUB;
          end else if (wait_done) begin
            mode <= want_pll ? MCG_PLL : MCG_MAIN;
          end
        end
        MCG_WAIT_PLL: begin
          if (!want_pll) begin
            mode <= MCG_MAIN;
          end else if (wait_done && main_tick) begin
            mode <= MCG_PLL;
          end
        end
        MCG_PLL: begin
          if (!want_pll && pll_tick) begin
            mode <= MCG_MAIN;
          end
        end
      endcase
    end
  end

  // source now feeding the machine clock; sub clock holds through osc wait
  always_comb begin
    unique case (mode)
      MCG_SUB, MCG_WAIT_OSC: cur_tick = sub_tick;
      MCG_PLL: cur_tick = pll_tick;
      default: cur_tick = main_tick;
    endcase
  end

  // registered clock enables and status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mclk_tick <= 1'b0;
      main_tick_out <= 1'b0;
      watch_tick <= 1'b0;
      pll_tick_out <= 1'b0;
      sub_running <= 1'b0;
      pll_running <= 1'b0;
      osc_waiting <= 1'b0;
    end else begin
      mclk_tick <= cur_tick;
      main_tick_out <= main_tick;
      watch_tick <= sub_tick;
      pll_tick_out <= pll_tick;
      sub_running <= (mode == MCG_SUB) || (mode == MCG_WAIT_OSC);
      pll_running <= (mode == MCG_PLL);
      osc_waiting <= (mode == MCG_WAIT_OSC) || (mode == MCG_WAIT_PLL);
    end
  end

  // peripheral taps: a tick each time the low timebase bits wrap
  for (genvar i = 0; i < PERI_TAPS; i++) begin : g_peri
    localparam int TAP = PERI_TAP_FIRST + 2 * i;
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        peri_tick[i] <= 1'b0;
      end else begin
        peri_tick[i] <= main_tick && !tbt_clr && (&tbt[TAP-1:0]);
      end
    end
  end

  // helper: low-speed ticks seen since the last sub tick
  logic [2:0] ls_since;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ls_since <= 3'h0;
    end else if (sub_tick) begin
      ls_since <= 3'h0;
    end else if (ctrl_write && (sub_div_select != sub_div)) begin
      ls_since <= 3'h7; // divide changed mid period: that period is not a ratio sample
    end else if (ls_osc_in && (ls_since != 3'h7)) begin
      ls_since <= ls_since + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_sub_req_in_main;
    (mode == MCG_MAIN) && want_sub;
  endsequence
  sequence s_enter_sub;
    (mode == MCG_TO_SUB) ##1 (mode == MCG_SUB);
  endsequence

  a_main_from_osc: assert property (main_tick_out |-> $past(hs_osc_in) && $past(main_ph))
    else $error("main tick not on second oscillation tick");
  a_sub_ratio: assert property (sub_tick && (ls_since != 3'h7) |->
    ls_since == (sub_div ? 3'h1 : 3'h3)) else $error("sub-clock ratio wrong");
  a_div_reset: assert property ($fell(sys_rst) |-> !sub_div)
    else $error("divide select not zero after reset");
  a_mult_legal: assert property (mult_code != MULT_ILLEGAL)
    else $error("illegal multiplier code held");
  a_mclk_source: assert property (mclk_tick |-> (sub_running ? watch_tick :
    pll_running ? pll_tick_out : main_tick_out)) else $error("machine tick from wrong source");
  a_wait_exit: assert property ((mode == MCG_WAIT_OSC) && !want_sub && wait_done |=>
    mode != MCG_WAIT_OSC) else $error("oscillation wait overran its tap");
  a_peri_tick: assert property (peri_tick[0] |-> $past(main_tick))
    else $error("peripheral tick off the main clock");
  a_watch_sub: assert property ((mode == MCG_SUB) && sub_tick |=> mclk_tick && watch_tick)
    else $error("sub mode machine tick not paired with watch tick");
  a_sub_priority: assert property (s_sub_req_in_main |=> mode == MCG_TO_SUB)
    else $error("sub select did not win");
  a_clean_switch: assert property (s_enter_sub |-> $past(sub_tick))
    else $error("switch to sub-clock off a sub tick");
endmodule // mcg_top

// File: design/mcg_pkg.sv
// constants and types for the machine clock generator
// assumes one 100 MHz system clock; oscillators arrive as one-cycle tick pulses
// Contract
// - main clock is oscillation clock halved
// - sub-clock is low-speed source divided 4/2
// - pll multiplies oscillation clock, five rates
// - machine clock from main, sub or pll
// - wait interval picked from four timebase taps
// - timebase divided ticks offered to peripherals
// - sub-clock drives watch timer, low-speed machine clock
// - divide select zero means /4, reset zero
// - sub select zero wins over pll select
package mcg_pkg;
  // timebase timer width, counted in main clock periods
  localparam int TBT_W = 18;
  // wait taps for ws codes 00..11 (bit index of timebase)
  localparam int WAIT_TAP0 = 9;
  localparam int WAIT_TAP1 = 12;
  localparam int WAIT_TAP2 = 14;
  localparam int WAIT_TAP3 = 16;
  // fixed pll lock wait: 2^14 oscillation periods is 2^13 main periods
  localparam int PLL_WAIT_TAP = 13;
  // peripheral tap outputs: tick every 2^(first + 2*i) main periods
  localparam int PERI_TAPS = 4;
  localparam int PERI_TAP_FIRST = 1;
  // width of the oscillator period measurement for the pll model
  localparam int PER_W = 16;
  // reset values of the control settings
  localparam logic RST_SUB_DIV = 1'b0;
  localparam logic RST_SUBCLK_SEL = 1'b1;
  localparam logic RST_PLL_SEL = 1'b1;
  localparam logic [1:0] RST_WAIT_SEL = 2'h0;
  localparam logic [2:0] RST_MULT = 3'h0;
  // forbidden multiplier code
  localparam logic [2:0] MULT_ILLEGAL = 3'h7;
  // clock modes and transitions
  typedef enum logic [2:0] {
    MCG_MAIN, MCG_TO_SUB, MCG_SUB, MCG_WAIT_OSC, MCG_WAIT_PLL, MCG_PLL
  } mcg_mode_t;
endpackage

// File: verif/mcg_osc_model.sv
// partner model: the two oscillator sources as one-cycle tick pulses
// assumes the generator samples its tick inputs on the rising edge of clk
module mcg_osc_model #(
  parameter int HS_P = 2, // clk cycles per oscillation period
  parameter int LS_P = 8 // clk cycles per low-speed period
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // ticks out
  output logic hs_osc_in,
  output logic ls_osc_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int hs_cnt; // phase within oscillation period
  int ls_cnt; // phase within low-speed period
  // sources restart on reset so window counts stay repeatable
  initial begin
    hs_osc_in = 1'b0;
    ls_osc_in = 1'b0;
    hs_cnt = 0;
    ls_cnt = 0;
    forever begin
      @(posedge clk);
      #1;
      if (sys_rst) begin
        hs_cnt = 0;
        ls_cnt = 0;
      end
      hs_osc_in = (hs_cnt == HS_P - 1);
      ls_osc_in = (ls_cnt == LS_P - 1);
      hs_cnt = (hs_cnt + 1) % HS_P;
      ls_cnt = (ls_cnt + 1) % LS_P;
    end
  end
endmodule // mcg_osc_model

// File: verif/tb_machine_clock_generator.sv
// self-checking bench for the machine clock generator
// assumes hs period 2 clk cycles and ls period 8, so pll rates up to x2 fit
module tb_machine_clock_generator;
  timeunit 1ns;
  timeprecision 100ps;
  import mcg_pkg::*;
  logic clk, sys_rst, hs_osc_in, ls_osc_in, ctrl_write, subclk_select, pll_select;
  logic [1:0] wait_select;
  logic pll_mult_bit0, pll_mult_bit1, pll_mult_bit2, sub_div_select;
  logic mclk_tick, main_tick_out, watch_tick, pll_tick_out;
  logic [PERI_TAPS-1:0] peri_tick;
  logic sub_running, pll_running, osc_waiting;
  int n_fail = 0; // mismatches
  int check_count = 0; // comparisons
  int cyc = 0; // hang guard
  int c_m, c_main, c_w, c_p, c_p0, c_p1, c_p2, c_p3; // window tick counts
  mcg_top dut_u (.clk(clk), .sys_rst(sys_rst), .hs_osc_in(hs_osc_in),
    .ls_osc_in(ls_osc_in), .ctrl_write(ctrl_write), .subclk_select(subclk_select),
    .pll_select(pll_select), .wait_select(wait_select), .pll_mult_bit0(pll_mult_bit0),
    .pll_mult_bit1(pll_mult_bit1), .pll_mult_bit2(pll_mult_bit2),
    .sub_div_select(sub_div_select), .mclk_tick(mclk_tick), .main_tick_out(main_tick_out),
    .watch_tick(watch_tick), .pll_tick_out(pll_tick_out), .peri_tick(peri_tick),
    .sub_running(sub_running), .pll_running(pll_running), .osc_waiting(osc_waiting));
  mcg_osc_model osc_u (.clk(clk), .sys_rst(sys_rst), .hs_osc_in(hs_osc_in),
    .ls_osc_in(ls_osc_in));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // tick counting and hang guard; the run needs about 56000 cycles
  always @(posedge clk) begin
    c_m += (mclk_tick === 1'b1);
    c_main += (main_tick_out === 1'b1);
    c_w += (watch_tick === 1'b1);
    c_p += (pll_tick_out === 1'b1);
    c_p0 += (peri_tick[0] === 1'b1);
    c_p1 += (peri_tick[1] === 1'b1);
    c_p2 += (peri_tick[2] === 1'b1);
    c_p3 += (peri_tick[3] === 1'b1);
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // counts compared with a small slack for window edges
  task automatic check_cnt(input int got, input int exp, input int tol);
    check_count++;
    if (got < exp - tol || got > exp + tol) begin
      n_fail++;
      $display("ERROR t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t status %b expected %b", $time, got, exp);
    end
  endtask
  // one control write: subclk, pll, wait, mult code, sub divide
  task automatic wr(input logic sc, input logic ps, input logic [1:0] ws,
                    input logic [2:0] m, input logic sd);
    @(posedge clk);
    #1;
    {ctrl_write, subclk_select, pll_select, wait_select} = {1'b1, sc, ps, ws};
    {pll_mult_bit2, pll_mult_bit1, pll_mult_bit0, sub_div_select} = {m, sd};
    @(posedge clk);
    #1;
    ctrl_write = 1'b0;
  endtask
  // counts cycles until status line sel (0 sub, 1 pll, 2 wait) reads val
  task automatic wait_st(input int sel, input logic val, input int lim, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      s = (sel == 0) ? sub_running : (sel == 1) ? pll_running : osc_waiting;
    end while (s !== val && n < lim);
    check_bit(s, val);
  endtask
  task automatic win(input int n);
    {c_m, c_main, c_w, c_p, c_p0, c_p1, c_p2, c_p3} = '0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // main mode after reset, default /4 sub-clock, timebase taps
  task automatic t_defaults();
    check_bit(sub_running, 1'b0);
    check_bit(pll_running, 1'b0);
    win(2048);
    check_cnt(c_main, 512, 1);
    check_cnt(c_m, c_main, 1);
    check_cnt(c_w, 64, 1);
    check_cnt(c_p0, 256, 1);
    check_cnt(c_p1, 64, 1);
    check_cnt(c_p2, 16, 1);
    check_cnt(c_p3, 4, 1);
  endtask
  // sub divide /2, then sub select wins over pll select
  task automatic t_sub();
    int n;
    wr(1'b1, 1'b1, 2'h0, 3'h0, 1'b1);
    win(400);
    check_cnt(c_w, 25, 1);
    wr(1'b0, 1'b0, 2'h0, 3'h0, 1'b1);
    wait_st(0, 1'b1, 100, n);
    check_bit(pll_running, 1'b0);
    win(400);
    check_cnt(c_m, c_w, 1);
  endtask
  // sub to main with wait codes 0 and 1: 2^9 and 2^12 main periods
  task automatic t_wait();
    int n;
    int taps[2] = '{WAIT_TAP0, WAIT_TAP1};
    for (int i = 0; i < 2; i++) begin
      if (i > 0) begin
        wr(1'b0, 1'b1, 2'h0, 3'h0, 1'b1);
        wait_st(0, 1'b1, 100, n);
      end
      wr(1'b1, 1'b1, 2'(i), 3'h0, 1'b1);
      wait_st(2, 1'b1, 100, n);
      wait_st(2, 1'b0, 40000, n);
      check_cnt(n, 4 * (1 << taps[i]), 16);
      check_bit(sub_running, 1'b0);
    end
  endtask
  // x2 pll, illegal code dropped, mult locked while pll runs, back to x1
  task automatic t_pll();
    int n;
    wr(1'b1, 1'b1, 2'h0, 3'h1, 1'b1);
    wr(1'b1, 1'b1, 2'h0, MULT_ILLEGAL, 1'b1);
    wr(1'b1, 1'b0, 2'h0, MULT_ILLEGAL, 1'b1);
    wait_st(1, 1'b1, 40000, n);
    check_cnt(n, 4 * (1 << PLL_WAIT_TAP), 16);
    wr(1'b1, 1'b0, 2'h0, 3'h0, 1'b1);
    win(400);
    check_cnt(c_p, 400, 2);
    check_cnt(c_m, c_p, 2);
    wr(1'b1, 1'b1, 2'h0, 3'h0, 1'b1);
    wait_st(1, 1'b0, 50, n);
    wr(1'b1, 1'b1, 2'h0, 3'h0, 1'b1);
    win(400);
    check_cnt(c_p, 200, 2);
    check_cnt(c_m, 100, 1);
  endtask
  // reset for 4 cycles, then the scenarios
  initial begin
    sys_rst = 1'b1;
    {ctrl_write, subclk_select, pll_select, wait_select} = {1'b0, 1'b1, 1'b1, 2'h0};
    {pll_mult_bit2, pll_mult_bit1, pll_mult_bit0, sub_div_select} = 4'h0;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_defaults();
    t_sub();
    t_wait();
    t_pll();
    print_verdict();
  end
endmodule // tb_machine_clock_generator
